// file: rtl/e1sb_pkg.sv
package e1sb_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] PAGE_TX        = 8'h0e;
    localparam logic [7:0] PAGE_RX        = 8'h0f;
    localparam logic [7:0] PAGE_CTRL      = 8'h01;
    localparam logic [7:0] ADDR_BYTE0     = 8'h10;
    localparam logic [7:0] ADDR_BYTE4     = 8'h14;
    localparam logic [7:0] ADDR_CTRL      = 8'h17;
    localparam int         CTRL_TXEN_BIT  = 0;
    localparam int         NUM_BYTES      = 5;
    localparam int         BITS_PER_BYTE  = 8;
    localparam logic [7:0] BYTE_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;
    localparam int         BUF_DEPTH      = 2;
    localparam int         BUF_WIDTH      = 5;
    localparam int         BUF_PTR_BITS   = 1;
endpackage

// file: rtl/e1sb_skid_buf.sv
`timescale 1ns/1ps
// ****************************************************************
// Two-entry buffer on the received spare-bit path
// ****************************************************************
module e1sb_skid_buf
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              in_valid,
    output logic                                   in_ready,
    input  wire logic [e1sb_pkg::BUF_WIDTH-1:0]    in_data,
    output logic                                   out_valid,
    input  wire logic                              out_ready,
    output logic [e1sb_pkg::BUF_WIDTH-1:0]         out_data
);
    typedef struct packed
    {
        logic [e1sb_pkg::BUF_DEPTH-1:0][e1sb_pkg::BUF_WIDTH-1:0] mem;
        logic [e1sb_pkg::BUF_PTR_BITS-1:0]                      wr;
        logic [e1sb_pkg::BUF_PTR_BITS-1:0]                      rd;
        logic [e1sb_pkg::BUF_PTR_BITS:0]                        cnt;
        logic                                                    rdy;
    } e1sb_buf_s;

    e1sb_buf_s s_q;
    e1sb_buf_s s_d;
    logic      push;
    logic      pop;

    // Ready has its own flop, so the framer sees no gated path
    assign in_ready  = s_q.rdy;
    assign out_valid = (s_q.cnt != 2'd0);
    assign out_data  = s_q.mem[s_q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next state
    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr          = s_q.wr + 1'b1;
        end
        if (pop)
        begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
        s_d.rdy = (s_d.cnt != 2'(e1sb_pkg::BUF_DEPTH));
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule

// file: rtl/e1sb_spare_bits.sv
`timescale 1ns/1ps
module e1sb_spare_bits
(
    input  wire logic                               clk,
    input  wire logic                               rst,
    // Microport, already synchronous strobes from the port front end
    input  wire logic [7:0]                         page,
    input  wire logic [7:0]                         addr,
    input  wire logic                               wr_en,
    input  wire logic                               rd_en,
    input  wire logic [7:0]                         wr_data,
    output logic [7:0]                              rd_data,
    // Framer timing
    input  wire logic                               crc4_mode,
    input  wire logic                               odd_frame_tick,
    input  wire logic [3:0]                         frame_num,
    // Transmit side, presented for channel zero of the next odd frame
    output logic [e1sb_pkg::NUM_BYTES-1:0]          tx_spare_bits,
    output logic                                    tx_spare_insert,
    // Receive side, bits taken from channel zero of each odd frame
    input  wire logic                               rx_valid,
    output logic                                    rx_ready,
    input  wire logic [e1sb_pkg::NUM_BYTES-1:0]     rx_spare_bits,
    input  wire logic                               rx_crc4_mode,
    input  wire logic [3:0]                         rx_frame_num
);
    // Short forms of the package sizes
    localparam int NB = e1sb_pkg::NUM_BYTES;
    localparam int BB = e1sb_pkg::BITS_PER_BYTE;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        // Software bytes and the copies that a frame group works from
        logic [NB-1:0][BB-1:0] tx_reg;
        logic [NB-1:0][BB-1:0] tx_shadow;
        logic [NB-1:0][BB-1:0] rx_reg;
        logic [NB-1:0][BB-1:0] rx_assem;
        // Slot counters, control bit and registered outputs
        logic [2:0]            tx_idx;
        logic [2:0]            rx_idx;
        logic                  txen;
        logic [7:0]            rd_data;
        logic [NB-1:0]         tx_bits;
        logic                  tx_ins;
    } e1sb_state_s;

    e1sb_state_s s_q;
    e1sb_state_s s_d;

    // Decode and datapath helpers
    logic          buf_valid;
    logic [NB-1:0] buf_data;
    logic          buf_ready;
    logic [2:0]    idx;
    logic          hit_tx;
    logic          hit_rx;
    logic          hit_ctrl;
    logic [2:0]    tx_slot;
    logic [2:0]    rx_slot;
    logic [NB-1:0] tx_col;

    // ****************************************************************
    // Receive buffering
    // ****************************************************************
    // Stall from the buffer holds back the framer, no bit is dropped
    e1sb_skid_buf i_e1sb_skid_buf
    (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_spare_bits),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    // The assembly register takes every word the cycle after it lands,
    // so at most one word is pending and the CRC-4 realign can use the
    // side info of the push itself
    assign buf_ready = 1'b1;

    // Address decode
    assign idx      = 3'(addr - e1sb_pkg::ADDR_BYTE0);
    assign hit_tx   = (page == e1sb_pkg::PAGE_TX) && (addr >= e1sb_pkg::ADDR_BYTE0)
                      && (addr <= e1sb_pkg::ADDR_BYTE4);
    assign hit_rx   = (page == e1sb_pkg::PAGE_RX) && (addr >= e1sb_pkg::ADDR_BYTE0)
                      && (addr <= e1sb_pkg::ADDR_BYTE4);
    assign hit_ctrl = (page == e1sb_pkg::PAGE_CTRL) && (addr == e1sb_pkg::ADDR_CTRL);

    // Bit slot within the byte: multiframe position or running count
    assign tx_slot = crc4_mode ? frame_num[3:1] : s_q.tx_idx;
    assign rx_slot = s_q.rx_idx;

    // ****************************************************************
    // Transmit column select
    // ****************************************************************
    // Slot 0 reads the live bytes so a write just before the group
    // still lands; later slots read the snapshot taken at slot 0
    for (genvar g = 0; g < NB; g++)
    begin : g_tx_col
        assign tx_col[g] = (tx_slot == 3'd0) ? s_q.tx_reg[g][3'd7 - tx_slot]
                                             : s_q.tx_shadow[g][3'd7 - tx_slot];
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.tx_ins = 1'b0;

        // Register writes; rx page is read only
        if (wr_en && hit_tx)
        begin
            s_d.tx_reg[idx] = wr_data;
        end
        // Clearing the enable mid-group stops insertion at the next frame
        if (wr_en && hit_ctrl)
        begin
            s_d.txen = wr_data[e1sb_pkg::CTRL_TXEN_BIT];
        end

        // Register reads
        if (rd_en)
        begin
            if (hit_tx)
            begin
                s_d.rd_data = s_q.tx_reg[idx];
            end
            else if (hit_rx)
            begin
                s_d.rd_data = s_q.rx_reg[idx];
            end
            else if (hit_ctrl)
            begin
                s_d.rd_data = {7'h00, s_q.txen};
            end
            else
            begin
                s_d.rd_data = e1sb_pkg::UNMAPPED_READ;
            end
        end

        // Transmit: one bit of every byte per odd frame
        if (odd_frame_tick)
        begin
            // Snapshot whole bytes at the start of each group of eight
            if (tx_slot == 3'd0)
            begin
                s_d.tx_shadow = s_q.tx_reg;
            end
            // MSB first: bit 7 goes in frame 1
            s_d.tx_bits = tx_col;
            // Insert flag follows the enable seen at the tick, one cycle wide
            s_d.tx_ins = s_q.txen;
            // Running slot for the plain case; under CRC-4 it follows the
            // multiframe, so a later switch back stays aligned
            s_d.tx_idx = crc4_mode ? 3'd0 : s_q.tx_idx + 3'd1;
            if (crc4_mode && frame_num[3:1] != 3'd7)
            begin
                s_d.tx_idx = frame_num[3:1] + 3'd1;
            end
        end

        // Receive: assemble, then publish whole bytes
        if (buf_valid)
        begin
            for (int n = 0; n < NB; n++)
            begin
                s_d.rx_assem[n][3'd7 - rx_slot] = buf_data[n];
            end
            if (rx_slot == 3'd7)
            begin
                for (int n = 0; n < NB; n++)
                begin
                    s_d.rx_reg[n] = {s_q.rx_assem[n][7:1], buf_data[n]};
                end
            end
            s_d.rx_idx = s_q.rx_idx + 3'd1;
        end

        // Multiframe position realigns the receive slot under CRC-4;
        // without it the slot just counts words, so a lost word skews
        // every later byte until reset
        if (rx_valid && rx_ready && rx_crc4_mode && !buf_valid)
        begin
            s_d.rx_idx = rx_frame_num[3:1];
        end
    end

    // ****************************************************************
    // State register and outputs
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        // Sync reset clears every byte, the enable and both slot counters
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign rd_data         = s_q.rd_data;
    assign tx_spare_bits   = s_q.tx_bits;
    assign tx_spare_insert = s_q.tx_ins;
endmodule

// file: verif/e1sb_chk.sv
`timescale 1ns/1ps
// ********
// Spare-bit checker
// ********
module e1sb_chk
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] page,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] wr_data,
    input  wire logic [7:0] rd_data,
    input  wire logic       crc4_mode,
    input  wire logic       odd_frame_tick,
    input  wire logic [3:0] frame_num,
    input  wire logic [4:0] tx_spare_bits,
    input  wire logic       tx_spare_insert,
    input  wire logic       rx_valid,
    input  wire logic       rx_ready
);
    logic [7:0] tm [5];
    logic [7:0] sn [5];
    logic [2:0] cnt_q;
    logic [2:0] slot_q;
    logic en_q;
    wire [2:0] slot = crc4_mode ? frame_num[3:1] : cnt_q;
    // Shadow of writes; snapshot at slot 0 so a group never mixes bytes
    always_ff @(posedge clk)
    begin
        if (odd_frame_tick)
            slot_q <= slot;
        if (rst)
        begin
            tm <= '{default: 8'h00};
            sn <= '{default: 8'h00};
            cnt_q <= 3'h0;
            en_q <= 1'b0;
        end
        else
        begin
            if (wr_en && page == e1sb_pkg::PAGE_TX
                && addr inside {[e1sb_pkg::ADDR_BYTE0:e1sb_pkg::ADDR_BYTE4]})
                tm[addr[2:0]] <= wr_data;
            if (wr_en && page == e1sb_pkg::PAGE_CTRL && addr == e1sb_pkg::ADDR_CTRL)
                en_q <= wr_data[e1sb_pkg::CTRL_TXEN_BIT];
            cnt_q <= cnt_q + 3'(odd_frame_tick);
            if (odd_frame_tick && slot == 3'h0)
                sn <= tm;
        end
    end
    // Column of the snapshot sent in one odd frame, earliest frame in bit 7
    function automatic logic [4:0] col(input logic [7:0] b [5], input logic [2:0] s);
        for (int n = 0; n < 5; n++)
            col[n] = b[n][3'h7 - s];
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_ins; tx_spare_insert ##1 !tx_spare_insert; endsequence
    property p_ins_on; odd_frame_tick && en_q |=> s_ins; endproperty
    a_ins_on: assert property (p_ins_on) else $error("insert pulse wrong");
    property p_ins_off; !(odd_frame_tick && en_q) |=> !tx_spare_insert; endproperty
    a_ins_off: assert property (p_ins_off) else $error("stray insert");
    property p_unmap; rd_en && page == 8'h00 |=> rd_data == e1sb_pkg::UNMAPPED_READ; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_rd_hold; !rd_en |=> $stable(rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_tx_crc; odd_frame_tick && crc4_mode |=> tx_spare_bits == col(sn, slot_q); endproperty
    a_tx_crc: assert property (p_tx_crc) else $error("multiframe bits");
    property p_tx_seq; odd_frame_tick && !crc4_mode |=> tx_spare_bits == col(sn, slot_q); endproperty
    a_tx_seq: assert property (p_tx_seq) else $error("odd frame bits");
    property p_bits_hold; !odd_frame_tick |=> $stable(tx_spare_bits); endproperty
    a_bits_hold: assert property (p_bits_hold) else $error("bits moved");
    // Buffer drains every cycle, so an offered word is never held back
    property p_rx_take; rx_valid |-> rx_ready; endproperty
    a_rx_take: assert property (p_rx_take) else $error("rx stalled");
endmodule
bind e1sb_spare_bits e1sb_chk i_e1sb_chk
(
    .clk(clk), .rst(rst), .page(page), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .rd_data(rd_data), .crc4_mode(crc4_mode),
    .odd_frame_tick(odd_frame_tick), .frame_num(frame_num),
    .tx_spare_bits(tx_spare_bits), .tx_spare_insert(tx_spare_insert),
    .rx_valid(rx_valid), .rx_ready(rx_ready)
);

// file: verif/e1sb_far_end.sv
`timescale 1ns/1ps
// ********
// Framer timing and far line
// ********
module e1sb_far_end
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic rx_ready,
    output logic tick,
    output logic [3:0] fnum,
    output logic rx_valid,
    output logic [4:0] rx_bits
);
    logic [3:0] cyc_q;
    logic [2:0] slot_q;
    // Word held until taken, then scrambled so a stale sample shows
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            {cyc_q, slot_q, tick, fnum, rx_valid, rx_bits} <= '0;
        end
        else
        begin
            tick <= 1'b0;
            cyc_q <= cyc_q + 4'h1;
            if (rx_valid && rx_ready)
            begin
                rx_valid <= 1'b0;
                rx_bits <= ~rx_bits;
            end
            if (cyc_q == (slow ? 4'hb : 4'h7))
            begin
                cyc_q <= 4'h0;
                tick <= 1'b1;
                fnum <= {slot_q, 1'b1};
                slot_q <= slot_q + 3'h1;
                rx_valid <= 1'b1;
                rx_bits <= {2'h0, slot_q} * 5'h05 + 5'h09;
            end
        end
    end
endmodule

// file: verif/test_e1_spare_bit_buffers.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", nm, e, a); end end
module test_e1_spare_bit_buffers;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] page = 8'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic crc4 = 1'b0;
    logic slow = 1'b0;
    logic tick, rx_valid, rx_ready, tx_spare_insert;
    logic [3:0] fnum;
    logic [4:0] rx_bits, tx_spare_bits;
    logic [7:0] rd_data;
    logic [7:0] tm [5] = '{8'ha5, 8'h3c, 8'hf0, 8'h0f, 8'h96};
    int err_total = 0;
    int comparisons = 0;
    always #25 clk = ~clk;
    e1sb_spare_bits i_e1sb_spare_bits (.clk(clk), .rst(rst), .page(page), .addr(addr),
        .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .crc4_mode(crc4),
        .odd_frame_tick(tick), .frame_num(fnum), .tx_spare_bits(tx_spare_bits),
        .tx_spare_insert(tx_spare_insert), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_spare_bits(rx_bits), .rx_crc4_mode(crc4), .rx_frame_num(fnum));
    e1sb_far_end i_e1sb_far_end (.clk(clk), .rst(rst), .slow(slow), .rx_ready(rx_ready),
        .tick(tick), .fnum(fnum), .rx_valid(rx_valid), .rx_bits(rx_bits));
    task automatic wr(input logic [7:0] p, a, d);
        @(posedge clk);
        {page, addr, wr_data, wr_en} <= {p, a, d, 1'b1};
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] p, a, e);
        @(posedge clk);
        {page, addr, rd_en} <= {p, a, 1'b1};
        @(posedge clk);
        rd_en <= 1'b0;
        #1 `CHK("rd_data", e, rd_data)
    endtask
    task automatic wt();
        for (int k = 0; k < 30 && tick !== 1'b1; k++)
            @(posedge clk) #1;
    endtask
    // One group from slot 0; byte 0 rewritten mid-group must not leak in
    task automatic grp(input logic ins);
        logic [4:0] e;
        for (int k = 0; k < 9 && fnum !== 4'h1; k++)
        begin
            @(posedge clk) #1;
            wt();
        end
        for (int s = 0; s < 8; s++)
        begin
            if (s > 0)
            begin
                @(posedge clk) #1;
                wt();
            end
            @(posedge clk) #1;
            for (int n = 0; n < 5; n++)
                e[n] = tm[n][7 - s];
            `CHK("tx_bits", e, tx_spare_bits)
            `CHK("insert", ins, tx_spare_insert)
            if (s == 3)
                wr(e1sb_pkg::PAGE_TX, e1sb_pkg::ADDR_BYTE0, ~tm[0]);
        end
        tm[0] = ~tm[0];
    endtask
    function automatic logic [7:0] rxp(input int n);
        for (int s = 0; s < 8; s++)
            rxp[7 - s] = 1'((s * 5 + 9) >> n);
    endfunction
    task automatic test_done();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog, far above the few hundred cycles the run needs
    initial
    begin
        #400_000;
        err_total++;
        test_done();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int n = 0; n < 5; n++)
        begin
            rd(e1sb_pkg::PAGE_TX, 8'(e1sb_pkg::ADDR_BYTE0 + n), e1sb_pkg::BYTE_RESET);
            rd(e1sb_pkg::PAGE_RX, 8'(e1sb_pkg::ADDR_BYTE0 + n), e1sb_pkg::BYTE_RESET);
        end
        wr(e1sb_pkg::PAGE_RX, e1sb_pkg::ADDR_BYTE0, 8'hff);
        rd(e1sb_pkg::PAGE_RX, e1sb_pkg::ADDR_BYTE0, e1sb_pkg::BYTE_RESET);
        rd(8'h00, e1sb_pkg::ADDR_BYTE0, e1sb_pkg::UNMAPPED_READ);
        rd(e1sb_pkg::PAGE_CTRL, e1sb_pkg::ADDR_CTRL, 8'h00);
        for (int n = 0; n < 5; n++)
            wr(e1sb_pkg::PAGE_TX, 8'(e1sb_pkg::ADDR_BYTE0 + n), tm[n]);
        for (int n = 0; n < 5; n++)
            rd(e1sb_pkg::PAGE_TX, 8'(e1sb_pkg::ADDR_BYTE0 + n), tm[n]);
        grp(1'b0);
        wr(e1sb_pkg::PAGE_CTRL, e1sb_pkg::ADDR_CTRL, 8'h01);
        rd(e1sb_pkg::PAGE_CTRL, e1sb_pkg::ADDR_CTRL, 8'h01);
        grp(1'b1);
        // Mode and frame spacing change on a clock edge, between groups
        @(posedge clk);
        crc4 <= 1'b1;
        slow <= 1'b1;
        grp(1'b1);
        rd(e1sb_pkg::PAGE_TX, e1sb_pkg::ADDR_BYTE0, tm[0]);
        for (int n = 0; n < 5; n++)
            rd(e1sb_pkg::PAGE_RX, 8'(e1sb_pkg::ADDR_BYTE0 + n), rxp(n));
        test_done();
    end
endmodule
